// ### dmr_pkg.sv
package dmr_pkg;

  // Command pins sampled on the command/address bus
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] ba;
    logic [12:0] addr;
  } dmr_cmd_t;

  localparam int MODE_W = 13;
  localparam int LAT_W = 5;

  // Command encodings {ras_n, cas_n, we_n} with cs_n low
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_WR = 3'h4;

  // Bank address selecting the target mode word
  localparam logic [2:0] BA_MODE_ZERO = 3'h0;
  localparam logic [2:0] BA_MODE_ONE = 3'h1;

  // Mode word zero field positions
  localparam int M0_BL_LO = 0;
  localparam int M0_BT = 3;
  localparam int M0_RDLAT_LO = 4;
  localparam int M0_DLL_RST = 8;
  localparam int M0_WR_LO = 9;
  localparam int M0_PPD = 12;

  // Mode word one field positions
  localparam int M1_DLL_DIS = 0;
  localparam int M1_DRV_A = 1;
  localparam int M1_ADDLAT_LO = 3;
  localparam int M1_DRV_B = 5;
  localparam int M1_WLEV = 7;

  // Column address bit choosing on-the-fly burst length
  localparam int ADDR_OTF = 12;

  localparam logic [MODE_W-1:0] MODE_ZERO_RST = 13'h0000;
  localparam logic [MODE_W-1:0] MODE_ONE_RST = 13'h0000;

  // Burst length codes
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_CHOP4 = 2'h2;

  // Drive strength code for calibration_resistor / 7
  localparam logic [1:0] DRV_CAL7 = 2'h1;

  // Timing counts in clock cycles
  localparam int DLL_LOCK_CYCLES = 512;
  localparam int MODE_UPDATE_CYCLES = 12;
  localparam int MODE_TO_MODE_CYCLES = 4;
  localparam int WRITE_LAT_BASE = 6;
  localparam logic [LAT_W-1:0] DLL_OFF_LAT = 5'h06;

  // Read latency code to clocks, zero for an illegal code
  function automatic logic [LAT_W-1:0] read_lat(input logic [2:0] code);
    case (code)
      3'h1: read_lat = 5'h05;
      3'h2: read_lat = 5'h06;
      3'h4: read_lat = 5'h08;
      3'h6: read_lat = 5'h0A;
      default: read_lat = 5'h00;
    endcase
  endfunction

  // Write recovery code to clocks, zero for a reserved code
  function automatic logic [3:0] wr_rec(input logic [2:0] code);
    case (code)
      3'h1: wr_rec = 4'h5;
      3'h2: wr_rec = 4'h6;
      3'h3: wr_rec = 4'h7;
      3'h4: wr_rec = 4'h8;
      3'h5: wr_rec = 4'hA;
      3'h6: wr_rec = 4'hC;
      default: wr_rec = 4'h0;
    endcase
  endfunction

endpackage

// ### dmr_burst_order.sv
`timescale 1ns/10ps
module dmr_burst_order (
  input wire logic [2:0] start_i, // Starting column bits 2:0
  input wire logic [2:0] beat_i, // Beat index within burst
  input wire logic interleave_i, // Interleaved ordering
  input wire logic chop_i, // Chop of four burst
  input wire logic write_i, // Write burst
  output logic [2:0] col_o // Column bits for this beat
);

  logic [1:0] low_rot;
  logic [2:0] seq_col;
  logic [2:0] rd_col;
  logic [2:0] wr_col;

  assign low_rot = start_i[1:0] + beat_i[1:0];
  // Upper nibble flips after four beats for full bursts
  assign seq_col = {start_i[2] ^ (beat_i[2] & ~chop_i), low_rot};
  assign rd_col = interleave_i ? (start_i ^ beat_i) : seq_col;
  assign wr_col = chop_i ? {start_i[2], beat_i[1:0]} : beat_i;
  assign col_o = write_i ? wr_col : rd_col;

endmodule // dmr_burst_order

// ### dmr_mode_config.sv
// Functional notes
// - New features apply only after mode_update_delay, except DLL disable (immediate); DLL reset longer.
// - Mode word zero bit 3 picks sequential or interleaved ordering.
// - Bits 1:0 pick chop four, burst of eight, or on-the-fly by A12.
// - Bursts wrap inside an aligned block of burst-length columns.
// - Reads start anywhere; sequential rotates, interleaved XORs beat count.
// - Writes aligned: chop uses bit 2 nibble, full burst runs 0 to 7.
// - Chop-four reads tri-state data drivers for last four slots.
// - Internal operations start at the same time for chop and full.
// - Bit 8 starts DLL reset and clears itself once started.
// - Write recovery bits 11:9 give 5,6,7,8,10 or 12 clocks.
// - Bit 12 keeps DLL running in precharge_powerdown, choosing exit delay.
// - Read latency bits 6:4 give 5, 6, 8 or 10 whole clocks.
// - First read data appears read_latency clocks after internal read.
// - Mode word one held until rewritten or reset pin; array untouched.
// - Bit 0 of mode word one disables DLL when set, enables when clear; enable needs DLL reset.
// - Self refresh stops DLL; exit restores and resets only if enabled.
// - With DLL off, latencies are six clocks and no termination.
// - Mode word one drive field selects impedance; calibration_resistor/7 primary.
// - Mode word one bits 4:3 pick additive latency 0, read_latency-1 or -2.
// - Mode word one bit 7 enters write leveling mode.
`timescale 1ns/10ps
module dmr_mode_config #(
  parameter int MOD_CYCLES = dmr_pkg::MODE_UPDATE_CYCLES,
  parameter int MRD_CYCLES = dmr_pkg::MODE_TO_MODE_CYCLES,
  parameter int DLLK_CYCLES = dmr_pkg::DLL_LOCK_CYCLES,
  parameter int WLB_CYCLES = dmr_pkg::WRITE_LAT_BASE
) (
  input wire logic sys_clk_i, // 250 MHz clock
  input wire logic reset_i, // Async reset, active high
  input wire dmr_pkg::dmr_cmd_t cmd_i, // Command/address pins
  input wire logic cke_i, // Clock enable pin
  input wire logic dram_reset_n_i, // Device reset pin, active low
  output logic [12:0] mode_word_zero_o, // Stored mode word zero
  output logic [12:0] mode_word_one_o, // Stored mode word one
  output logic update_busy_o, // Mode update delay running
  output logic mrd_busy_o, // Mode-to-mode delay running
  output logic dll_reset_o, // DLL reset start pulse
  output logic dll_enabled_o, // DLL running
  output logic dll_locked_o, // DLL lock time elapsed
  output logic [4:0] read_lat_o, // Total read latency clocks
  output logic [4:0] write_lat_o, // Total write latency clocks
  output logic [3:0] wr_cycles_o, // Write recovery clocks
  output logic ppd_slow_exit_o, // Slow power-down exit needed
  output logic [1:0] drive_sel_o, // Output impedance select
  output logic drive_primary_o, // Impedance is calibration_resistor/7
  output logic wr_level_o, // Write leveling mode
  output logic odt_allowed_o, // Termination may be used
  output logic lat_fault_o, // Illegal latency setting
  output logic beat_valid_o, // Burst beat slot carries data
  output logic [2:0] beat_col_o, // Column bits of the beat
  output logic beat_read_o, // Beat belongs to a read
  output logic dq_oe_o // Data/strobe driver enable
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_WAIT = 3'h2,
    ST_BEAT = 3'h4
  } dmr_bst_t;

  localparam int CNT_W = 10;
  localparam logic [CNT_W-1:0] MOD_LOAD = CNT_W'(MOD_CYCLES - 1);
  localparam logic [CNT_W-1:0] MRD_LOAD = CNT_W'(MRD_CYCLES - 1);
  localparam logic [CNT_W-1:0] DLLK_LOAD = CNT_W'(DLLK_CYCLES - 1);
  localparam logic [4:0] WLB_LAT = 5'(WLB_CYCLES);

  // Pin synchronisers
  dmr_pkg::dmr_cmd_t cmd_s1_reg, cmd_reg;
  logic cke_s1_reg, cke_reg, cke_old_reg;
  logic rstn_s1_reg, rstn_reg;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cmd_s1_reg <= '1;
      cmd_reg <= '1;
      cke_s1_reg <= 1'b0;
      cke_reg <= 1'b0;
      cke_old_reg <= 1'b0;
      rstn_s1_reg <= 1'b0;
      rstn_reg <= 1'b0;
    end else begin
      cmd_s1_reg <= cmd_i;
      cmd_reg <= cmd_s1_reg;
      cke_s1_reg <= cke_i;
      cke_reg <= cke_s1_reg;
      cke_old_reg <= cke_reg;
      rstn_s1_reg <= dram_reset_n_i;
      rstn_reg <= rstn_s1_reg;
    end
  end

  // Command decode
  wire [2:0] cmd_code = {cmd_reg.ras_n, cmd_reg.cas_n, cmd_reg.we_n};
  wire cmd_sel = ~cmd_reg.cs_n & cke_reg;
  wire is_mrs = cmd_sel & (cmd_code == dmr_pkg::CMD_MRS);
  wire is_rd = cmd_sel & (cmd_code == dmr_pkg::CMD_RD);
  wire is_wr = cmd_sel & (cmd_code == dmr_pkg::CMD_WR);
  wire sr_enter = ~cmd_reg.cs_n & cke_old_reg & ~cke_reg
    & (cmd_code == dmr_pkg::CMD_REF);
  wire wr_zero = is_mrs & (cmd_reg.ba == dmr_pkg::BA_MODE_ZERO);
  wire wr_one = is_mrs & (cmd_reg.ba == dmr_pkg::BA_MODE_ONE);

  // Stored and active mode words
  logic [12:0] mw0_reg, mw0_next, mw1_reg, mw1_next;
  logic [12:0] act0_reg, act1_reg;
  logic [CNT_W-1:0] mod_cnt_reg, mrd_cnt_reg, dllk_cnt_reg;
  logic mod_run_reg, in_sr_reg, sr_dll_reg, dll_run_reg, locked_reg;

  wire rst_self = mw0_reg[dmr_pkg::M0_DLL_RST];
  wire mod_done = mod_run_reg & (mod_cnt_reg == '0);

  always_comb begin
    mw0_next = mw0_reg;
    mw1_next = mw1_reg;
    if (rst_self)
      mw0_next[dmr_pkg::M0_DLL_RST] = 1'b0;
    // Whole row bus replaces the word
    if (wr_zero)
      mw0_next = cmd_reg.addr;
    if (wr_one)
      mw1_next = cmd_reg.addr;
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mw0_reg <= dmr_pkg::MODE_ZERO_RST;
      mw1_reg <= dmr_pkg::MODE_ONE_RST;
    end else if (!rstn_reg) begin
      mw0_reg <= dmr_pkg::MODE_ZERO_RST;
      mw1_reg <= dmr_pkg::MODE_ONE_RST;
    end else begin
      mw0_reg <= mw0_next;
      mw1_reg <= mw1_next;
    end
  end

  // Mode update delay gates the active copy
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mod_run_reg <= 1'b0;
      mod_cnt_reg <= '0;
      act0_reg <= dmr_pkg::MODE_ZERO_RST;
      act1_reg <= dmr_pkg::MODE_ONE_RST;
    end else if (!rstn_reg) begin
      mod_run_reg <= 1'b0;
      mod_cnt_reg <= '0;
      act0_reg <= dmr_pkg::MODE_ZERO_RST;
      act1_reg <= dmr_pkg::MODE_ONE_RST;
    end else if (is_mrs) begin
      mod_run_reg <= 1'b1;
      mod_cnt_reg <= MOD_LOAD;
    end else if (mod_done) begin
      mod_run_reg <= 1'b0;
      act0_reg <= mw0_reg;
      act1_reg <= mw1_reg;
    end else if (mod_run_reg) begin
      mod_cnt_reg <= mod_cnt_reg - 1'b1;
    end
  end

  // Mode-to-mode delay indicator; spacing itself is the controller's duty
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i)
      mrd_cnt_reg <= '0;
    else if (is_mrs)
      mrd_cnt_reg <= MRD_LOAD;
    else if (mrd_cnt_reg != '0)
      mrd_cnt_reg <= mrd_cnt_reg - 1'b1;
  end

  // DLL control: enable bit, self refresh and reset timing
  wire dll_bit_on = ~mw1_reg[dmr_pkg::M1_DLL_DIS];
  wire sr_exit = in_sr_reg & cke_reg & ~cke_old_reg;
  wire sr_restart = sr_exit & sr_dll_reg;
  wire dll_start = (rst_self | sr_restart) & dll_bit_on;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      in_sr_reg <= 1'b0;
      sr_dll_reg <= 1'b0;
      dll_run_reg <= 1'b0;
    end else begin
      if (sr_enter) begin
        in_sr_reg <= 1'b1;
        sr_dll_reg <= dll_run_reg;
      end else if (sr_exit) begin
        in_sr_reg <= 1'b0;
      end
      if (sr_enter | ~dll_bit_on | ~rstn_reg)
        dll_run_reg <= 1'b0;
      else if (dll_start)
        dll_run_reg <= 1'b1;
    end
  end

  // Lock counter; a new reset restarts it
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      dllk_cnt_reg <= '0;
      locked_reg <= 1'b0;
    end else if (dll_start) begin
      dllk_cnt_reg <= DLLK_LOAD;
      locked_reg <= 1'b0;
    end else if (!dll_run_reg) begin
      locked_reg <= 1'b0;
    end else if (dllk_cnt_reg != '0) begin
      dllk_cnt_reg <= dllk_cnt_reg - 1'b1;
    end else if (!locked_reg) begin
      locked_reg <= 1'b1;
    end
  end

  // Latency and feature decode from the active words
  wire [4:0] rdl_raw = dmr_pkg::read_lat(act0_reg[dmr_pkg::M0_RDLAT_LO +: 3]);
  wire [4:0] rdl_eff = dll_run_reg ? rdl_raw : dmr_pkg::DLL_OFF_LAT;
  wire [4:0] wlb_eff = dll_run_reg ? WLB_LAT : dmr_pkg::DLL_OFF_LAT;
  wire [1:0] addl_code = act1_reg[dmr_pkg::M1_ADDLAT_LO +: 2];
  wire [4:0] addl_lat = (addl_code == 2'h1) ? rdl_eff - 5'h01 :
    (addl_code == 2'h2) ? rdl_eff - 5'h02 : 5'h00;
  wire [4:0] rl_tot = addl_lat + rdl_eff;
  wire [4:0] wl_tot = addl_lat + wlb_eff;
  wire lat_bad = (rdl_raw == 5'h00) | (addl_code == 2'h3);
  wire [3:0] wr_dec = dmr_pkg::wr_rec(act0_reg[dmr_pkg::M0_WR_LO +: 3]);
  wire [1:0] drv = {act1_reg[dmr_pkg::M1_DRV_B], act1_reg[dmr_pkg::M1_DRV_A]};

  // Burst sequencing
  dmr_bst_t st_reg, st_next;
  logic [4:0] lat_cnt_reg;
  logic [2:0] beat_reg, start_reg;
  logic chop_reg, rd_reg, ilv_reg;
  logic [2:0] beat_next, col_next;

  wire [1:0] bl_code = act0_reg[dmr_pkg::M0_BL_LO +: 2];
  wire cmd_chop = (bl_code == dmr_pkg::BL_CHOP4) |
    ((bl_code == dmr_pkg::BL_OTF) & ~cmd_reg.addr[dmr_pkg::ADDR_OTF]);
  wire burst_cmd = is_rd | is_wr;
  wire lat_zero = (lat_cnt_reg == 5'h00);
  wire last_beat = (beat_reg == 3'h7);

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      ST_IDLE: if (burst_cmd) st_next = ST_WAIT;
      ST_WAIT: if (lat_zero) st_next = ST_BEAT;
      ST_BEAT: if (last_beat) st_next = ST_IDLE;
      default: st_next = ST_IDLE;
    endcase
    if (burst_cmd)
      st_next = ST_WAIT;
  end

  assign beat_next = (st_reg == ST_BEAT) ? beat_reg + 3'h1 : 3'h0;

  dmr_burst_order u_order (
    .start_i(start_reg),
    .beat_i(beat_next),
    .interleave_i(ilv_reg),
    .chop_i(chop_reg),
    .write_i(~rd_reg),
    .col_o(col_next)
  );

  wire slot_live = (st_next == ST_BEAT) & (~burst_cmd);
  wire upper = beat_next[2];
  wire slot_data = slot_live & ~(chop_reg & upper);

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_reg <= ST_IDLE;
      lat_cnt_reg <= 5'h00;
      beat_reg <= 3'h0;
      start_reg <= 3'h0;
      chop_reg <= 1'b0;
      rd_reg <= 1'b0;
      ilv_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      if (burst_cmd) begin
        // Same launch point for chop and full bursts
        lat_cnt_reg <= (is_rd ? rl_tot : wl_tot) - 5'h01;
        start_reg <= cmd_reg.addr[2:0];
        chop_reg <= cmd_chop;
        rd_reg <= is_rd;
        ilv_reg <= act0_reg[dmr_pkg::M0_BT];
      end else if (st_reg == ST_WAIT) begin
        lat_cnt_reg <= lat_cnt_reg - 5'h01;
      end
      if (st_next == ST_BEAT)
        beat_reg <= beat_next;
    end
  end

  // Registered outputs
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      beat_valid_o <= 1'b0;
      beat_col_o <= 3'h0;
      beat_read_o <= 1'b0;
      dq_oe_o <= 1'b0;
    end else begin
      beat_valid_o <= slot_data;
      beat_col_o <= col_next;
      beat_read_o <= slot_live & rd_reg;
      dq_oe_o <= slot_data & rd_reg;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mode_word_zero_o <= dmr_pkg::MODE_ZERO_RST;
      mode_word_one_o <= dmr_pkg::MODE_ONE_RST;
      update_busy_o <= 1'b0;
      mrd_busy_o <= 1'b0;
      dll_reset_o <= 1'b0;
      dll_enabled_o <= 1'b0;
      dll_locked_o <= 1'b0;
      read_lat_o <= 5'h00;
      write_lat_o <= 5'h00;
      wr_cycles_o <= 4'h0;
      ppd_slow_exit_o <= 1'b1;
      drive_sel_o <= 2'h0;
      drive_primary_o <= 1'b0;
      wr_level_o <= 1'b0;
      odt_allowed_o <= 1'b0;
      lat_fault_o <= 1'b0;
    end else begin
      mode_word_zero_o <= mw0_reg;
      mode_word_one_o <= mw1_reg;
      update_busy_o <= mod_run_reg;
      mrd_busy_o <= (mrd_cnt_reg != '0);
      dll_reset_o <= dll_start;
      dll_enabled_o <= dll_run_reg;
      dll_locked_o <= locked_reg;
      read_lat_o <= rl_tot;
      write_lat_o <= wl_tot;
      wr_cycles_o <= wr_dec;
      ppd_slow_exit_o <= ~act0_reg[dmr_pkg::M0_PPD];
      drive_sel_o <= drv;
      drive_primary_o <= (drv == dmr_pkg::DRV_CAL7);
      wr_level_o <= act1_reg[dmr_pkg::M1_WLEV];
      odt_allowed_o <= dll_run_reg;
      lat_fault_o <= lat_bad;
    end
  end

endmodule // dmr_mode_config

// ### dmr_mode_properties.sv
`timescale 1ns/10ps
module dmr_mode_checker (
  input wire logic sys_clk_i, // System clock
  input wire logic reset_i, // Async reset
  input wire logic cke_i, // Clock enable pin
  input wire logic [12:0] mode_word_zero_o, // Stored word zero
  input wire logic update_busy_o, // Update delay running
  input wire logic mrd_busy_o, // Mode-to-mode delay running
  input wire logic dll_reset_o, // DLL reset pulse
  input wire logic dll_enabled_o, // DLL running
  input wire logic [3:0] wr_cycles_o, // Write recovery
  input wire logic [1:0] drive_sel_o, // Impedance select
  input wire logic drive_primary_o, // Primary impedance
  input wire logic odt_allowed_o, // Termination allowed
  input wire logic beat_valid_o, // Beat slot carries data
  input wire logic beat_read_o, // Beat slot of a read
  input wire logic dq_oe_o // Data driver enable
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  // Bit 8 write, or self refresh exit three samples back
  dll_pulse_a: assert property (
    dll_reset_o |-> mode_word_zero_o[8] ||
      ($past(cke_i, 3) && !$past(cke_i, 4)))
    else $error("DLL reset without a cause");
  bit8_clear_a: assert property (
    mode_word_zero_o[8] |=> !mode_word_zero_o[8])
    else $error("DLL reset bit did not clear");
  update_hold_a: assert property (
    $rose(update_busy_o) |-> update_busy_o[*8])
    else $error("Update delay ended early");
  // Command cycle plus three busy cycles
  mrd_hold_a: assert property (
    $rose(mrd_busy_o) |-> mrd_busy_o[*3] ##1 !mrd_busy_o)
    else $error("Mode spacing window wrong length");
  wr_legal_a: assert property (
    wr_cycles_o inside {4'h0, 4'h5, 4'h6, 4'h7, 4'h8, 4'hA, 4'hC})
    else $error("Illegal write recovery value");
  drive_code_a: assert property (
    drive_primary_o == (drive_sel_o == dmr_pkg::DRV_CAL7))
    else $error("Primary impedance flag wrong");
  odt_dll_a: assert property (
    !dll_enabled_o && !$past(dll_enabled_o) |-> !odt_allowed_o)
    else $error("Termination allowed with DLL off");
  chop_tristate_a: assert property (
    beat_read_o && !beat_valid_o |-> !dq_oe_o)
    else $error("Driver on in chopped slot");
  read_oe_a: assert property (
    beat_read_o && beat_valid_o |-> dq_oe_o)
    else $error("Driver off in read slot");
  burst_window_a: assert property (
    $rose(beat_read_o) |-> beat_read_o[*8] ##1 !beat_read_o)
    else $error("Read window not eight slots");
endmodule // dmr_mode_checker

bind dmr_mode_config dmr_mode_checker u_checker (
  .sys_clk_i(sys_clk_i), .reset_i(reset_i), .cke_i(cke_i),
  .mode_word_zero_o(mode_word_zero_o), .update_busy_o(update_busy_o),
  .mrd_busy_o(mrd_busy_o),
  .dll_reset_o(dll_reset_o), .dll_enabled_o(dll_enabled_o),
  .wr_cycles_o(wr_cycles_o), .drive_sel_o(drive_sel_o),
  .drive_primary_o(drive_primary_o), .odt_allowed_o(odt_allowed_o),
  .beat_valid_o(beat_valid_o), .beat_read_o(beat_read_o),
  .dq_oe_o(dq_oe_o)
);

// ### dmr_ctrl_model.sv
`timescale 1ns/10ps
module dmr_ctrl_model #(
  parameter int MOD_WAIT = 20,
  parameter int LOCK_WAIT = 512
) (
  input wire logic sys_clk_i, // System clock
  output dmr_pkg::dmr_cmd_t cmd_o, // Command/address pins
  output logic cke_o // Clock enable
);
  initial begin
    cmd_o = 20'hFFFFF;
    cke_o = 1'h1;
  end

  // One command cycle, then deselect with inverted pins
  // Clock enable moves in the same cycle as the command it qualifies
  task automatic issue(input logic [2:0] op, input logic [2:0] ba,
                       input logic [12:0] addr, input logic cke = 1'h1);
    @(posedge sys_clk_i);
    cmd_o <= {1'h0, op, ba, addr};
    cke_o <= cke;
    @(posedge sys_clk_i);
    cmd_o <= {1'h1, ~op, ~ba, ~addr};
  endtask

  // Whole word each time; idle covers both mode delays
  task automatic mrs(input logic [2:0] ba, input logic [12:0] word);
    issue(dmr_pkg::CMD_MRS, ba, word);
    repeat (MOD_WAIT) @(posedge sys_clk_i);
    if (ba == dmr_pkg::BA_MODE_ZERO && word[8])
      repeat (LOCK_WAIT) @(posedge sys_clk_i);
    #1;
  endtask
endmodule // dmr_ctrl_model

// ### testbench.sv
`timescale 1ns/10ps
module testbench;
  logic sys_clk_i;
  logic reset_i;
  logic dram_reset_n_i;
  dmr_pkg::dmr_cmd_t cmd;
  logic cke;
  logic [12:0] mw0, mw1;
  logic upd, mrd, dllr, dlle, dlll, ppd, prim, wlev, odt, fault, bv, brd, oe;
  logic [4:0] rl, wl;
  logic [3:0] wrc;
  logic [1:0] drv, bl;
  logic [2:0] bcol;
  logic bt;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  int resets = 0;

  dmr_mode_config #(.DLLK_CYCLES(8)) u_dut (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .cmd_i(cmd), .cke_i(cke),
    .dram_reset_n_i(dram_reset_n_i), .mode_word_zero_o(mw0),
    .mode_word_one_o(mw1), .update_busy_o(upd), .mrd_busy_o(mrd),
    .dll_reset_o(dllr), .dll_enabled_o(dlle), .dll_locked_o(dlll),
    .read_lat_o(rl), .write_lat_o(wl), .wr_cycles_o(wrc),
    .ppd_slow_exit_o(ppd), .drive_sel_o(drv), .drive_primary_o(prim),
    .wr_level_o(wlev), .odt_allowed_o(odt), .lat_fault_o(fault),
    .beat_valid_o(bv), .beat_col_o(bcol), .beat_read_o(brd), .dq_oe_o(oe)
  );
  dmr_ctrl_model #(.LOCK_WAIT(16)) u_ctrl (
    .sys_clk_i(sys_clk_i), .cmd_o(cmd), .cke_o(cke)
  );

  initial begin
    sys_clk_i = 1'h0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  task automatic test_done();
    $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [12:0] seen, input logic [12:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [4:0] rdl_of(input logic [2:0] c);
    case (c)
      3'h1: return 5'h05;
      3'h2: return 5'h06;
      3'h4: return 5'h08;
      default: return 5'h0A;
    endcase
  endfunction

  function automatic logic [3:0] wr_of(input logic [2:0] c);
    return (c < 3'h5) ? {1'h0, c} + 4'h4 : {c, 1'h0};
  endfunction

  function automatic logic [4:0] addl_of(input logic [1:0] a,
                                         input logic [4:0] rdl);
    return a == 2'h1 ? rdl - 5'h01 : a == 2'h2 ? rdl - 5'h02 : 5'h00;
  endfunction

  function automatic logic [2:0] col_of(input logic [2:0] s,
    input logic [2:0] b, input logic il, input logic ch, input logic wr);
    if (wr)
      return ch ? {s[2], b[1:0]} : b;
    if (il)
      return s ^ b;
    return {s[2] ^ b[2], s[1:0] + b[1:0]};
  endfunction

  task automatic burst(input logic wr, input logic [2:0] s, input logic a12,
                       input logic [4:0] lat);
    logic chop;
    int first;
    int b;
    chop = bl == dmr_pkg::BL_CHOP4 || (bl == dmr_pkg::BL_OTF && !a12);
    first = -1;
    u_ctrl.issue(wr ? dmr_pkg::CMD_WR : dmr_pkg::CMD_RD, 3'h0,
                 {a12, 9'h000, s});
    for (int c = 1; c < 40; c++) begin
      @(posedge sys_clk_i);
      #1;
      if (first < 0 && bv === 1'h1) begin
        first = c;
        // Pin sync and output register add two cycles
        check(13'(c), 13'(lat) + 13'h0002);
      end
      b = c - first;
      if (first >= 0 && b < 8) begin
        check(bv, !(chop && b > 3));
        check(brd, !wr);
        if (!wr)
          check(oe, !(chop && b > 3));
        if (bv === 1'h1)
          check(bcol, col_of(s, 3'(b), bt, chop, wr));
      end
    end
    check(13'(first >= 0), 13'h0001);
  endtask

  always @(posedge sys_clk_i) begin
    cycles++;
    if (dllr === 1'h1)
      resets++;
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end

  initial begin
    logic [12:0] v, w1;
    logic [4:0] rdl;
    logic [2:0] clc;
    logic [1:0] alc, d;
    void'($urandom(56));
    reset_i = 1'h1;
    dram_reset_n_i = 1'h1;
    repeat (2) @(posedge sys_clk_i);
    reset_i <= 1'h0;
    @(posedge sys_clk_i);
    #1;
    check(mw0, 13'h0000);
    check(ppd, 1'h1);
    check(rl, 5'h06);
    for (int i = 0; i < 2; i++) begin
      d = (i == 0) ? dmr_pkg::DRV_CAL7 : 2'($urandom);
      alc = (i == 0) ? 2'h0 : 2'($urandom_range(2));
      w1 = {5'h00, i == 0, 1'h0, d[1], alc, 1'h0, d[0], 1'h0};
      u_ctrl.mrs(dmr_pkg::BA_MODE_ONE, w1);
      check(mw1, w1);
      check(drv, d);
      check(prim, d == 2'h1);
      check(wlev, w1[7]);
    end
    u_ctrl.mrs(3'h2, 13'h1FFF);
    check(mw1, w1);
    check(mw0, 13'h0000);
    for (int i = 0; i < 6; i++) begin
      clc = (i % 4 == 0) ? 3'h1 : 3'(i % 4 * 2);
      bl = 2'(i % 3);
      bt = i[0];
      v = {1'($urandom), 3'(i + 1), i == 0, 1'h0, clc, bt, 1'h0, bl};
      u_ctrl.mrs(dmr_pkg::BA_MODE_ZERO, v);
      rdl = rdl_of(clc);
      check(mw0, v & 13'h1EFF);
      check(wrc, wr_of(3'(i + 1)));
      check(ppd, !v[12]);
      check(rl, addl_of(alc, rdl) + rdl);
      check(wl, addl_of(alc, rdl) + 5'h06);
      check(fault, 1'h0);
      if (i == 0) begin
        check(13'(resets), 13'h0001);
        check(dlll, 1'h1);
      end
      for (int k = 0; k < 4; k++)
        burst(k[0], 3'($urandom), k[1],
              addl_of(alc, rdl) + (k[0] ? 5'h06 : rdl));
    end
    u_ctrl.mrs(dmr_pkg::BA_MODE_ONE, w1 | 13'h0001);
    u_ctrl.mrs(dmr_pkg::BA_MODE_ZERO, 13'h0040);
    check(dlle, 1'h0);
    check(odt, 1'h0);
    check(rl, addl_of(alc, 5'h06) + 5'h06);
    u_ctrl.mrs(dmr_pkg::BA_MODE_ONE, w1);
    u_ctrl.mrs(dmr_pkg::BA_MODE_ZERO, 13'h0120);
    check(dlle, 1'h1);
    check(dlll, 1'h1);
    check(odt, 1'h1);
    check(13'(resets), 13'h0002);
    // Self refresh with DLL running: off inside, reset on exit
    u_ctrl.issue(dmr_pkg::CMD_REF, 3'h0, 13'h0000, 1'h0);
    repeat (4) @(posedge sys_clk_i);
    #1;
    check(dlle, 1'h0);
    u_ctrl.issue(3'h7, 3'h0, 13'h0000, 1'h1);
    repeat (16) @(posedge sys_clk_i);
    #1;
    check(dlle, 1'h1);
    check(dlll, 1'h1);
    check(13'(resets), 13'h0003);
    @(posedge sys_clk_i);
    dram_reset_n_i <= 1'h0;
    repeat (5) @(posedge sys_clk_i);
    #1;
    check(mw0, 13'h0000);
    check(mw1, 13'h0000);
    @(posedge sys_clk_i);
    dram_reset_n_i <= 1'h1;
    test_done();
  end
endmodule // testbench
